// file: inc/spdr_pkg.sv
// constants, field layout and types for the receive status and user buffers
package spdr_pkg;
   localparam logic [7:0] REG_CFG = 8'h10;
   localparam logic [7:0] REG_CSSEL = 8'h11;
   localparam logic [7:0] REG_INTSTAT = 8'h12;
   localparam logic [7:0] REG_INTMASK = 8'h13;
   localparam logic [7:0] REG_UBADDR = 8'h14;
   localparam logic [7:0] REG_UBDATA = 8'h15;
   localparam logic [7:0] REG_QSTAT = 8'h16;
   localparam logic [7:0] REG_IUCNT = 8'h17;
   localparam logic [7:0] CS_BASE = 8'h20;
   localparam logic [7:0] CS_LAST = 8'h37;
   localparam logic [7:0] Q_BASE = 8'h50;
   localparam logic [7:0] Q_LAST = 8'h59;
   localparam int CFG_SIZE_BIT = 0;
   localparam int CFG_MODE_LSB = 1;
   localparam int CFG_FLAGMODE_BIT = 3;
   localparam int INT_CS_BIT = 0;
   localparam int INT_UB_BIT = 1;
   localparam int PRO_BIT = 0;
   localparam int CAT_LSB = 12;
   localparam logic [3:0] CFG_RST = 4'h0;
   localparam logic MASK_RST = 1'b0;
   localparam logic CSSEL_RST = 1'b0;
   localparam int CS_BITS = 192;
   localparam logic [7:0] CS_LAST_IDX = 8'hbf;
   localparam int CMP_BITS = 40;
   localparam int UB_BITS = 768;
   localparam logic [9:0] UB_LAST_LARGE = 10'h2ff;
   localparam logic [9:0] UB_LAST_SMALL = 10'h17f;
   localparam logic [6:0] UB_BYTES_LARGE = 7'h60;
   localparam logic [6:0] UB_BYTES_SMALL = 7'h30;
   localparam logic [6:0] IU_MAX = 7'h60;
   localparam logic [3:0] ZERO_END = 4'h8;
   localparam logic [2:0] IU_LAST_BIT = 3'h6;
   localparam logic [7:0] IU_LEAD = 8'h80;
   localparam logic [7:0] PRE_Z_A = 8'he8;
   localparam logic [7:0] PRE_Z_B = 8'h17;
   localparam logic [7:0] PRE_X_A = 8'he2;
   localparam logic [7:0] PRE_X_B = 8'h1d;
   localparam logic [15:0] Q_POLY = 16'h1021;
   localparam logic [15:0] Q_INIT = 16'h0000;
   localparam logic Q_INVERT = 1'b1;
   localparam int Q_DATA_BITS = 80;
   localparam logic [1:0] UBM_CFG_OFF = 2'h0;
   localparam logic [1:0] UBM_CFG_BLOCK = 2'h1;
   localparam logic [1:0] UBM_CFG_AUTO = 2'h2;
   localparam logic [3:0] CAT_NONE = 4'h0;
   localparam logic [3:0] CAT_AES18 = 4'h4;
   localparam logic [3:0] CAT_SMALL = 4'h8;
   localparam logic [3:0] CAT_USER = 4'hc;
   typedef enum logic [1:0] {UBM_OFF, UBM_BLOCK, UBM_MSG} spdr_ubm_e;
   typedef enum logic [1:0] {MS_IDLE, MS_IU, MS_GAP} spdr_msg_e;
endpackage : spdr_pkg

// file: inc/spdr_evt_if.sv
// event toggle carried from one clock domain to another
`timescale 1ns/1ps
interface spdr_evt_if;
   logic srcTog;
   logic dstPulse;
   modport src (output srcTog, input dstPulse);
   modport sync (input srcTog, output dstPulse);
endinterface : spdr_evt_if

// file: rtl/spdr_evt_sync.sv
// three-stage toggle synchroniser producing one pulse per toggle
`timescale 1ns/1ps
module spdr_evt_sync
(
   input wire logic clk,
   input wire logic arst_n,
   spdr_evt_if.sync evt
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic seen_r;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= evt.srcTog;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         seen_r <= 1'b0;
      else if (s2_r == s3_r)
         seen_r <= s3_r;
   end
   assign evt.dstPulse = (s2_r == s3_r) && (s3_r != seen_r);
endmodule : spdr_evt_sync

// file: rtl/spdr_rx_buffers.sv
// receive channel-status and user-bit buffers with message parsing and q subcode check
`timescale 1ns/1ps
module spdr_rx_buffers
   import spdr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic linkClk,
   input wire logic subValid,
   input wire logic [7:0] subPreamble,
   input wire logic csBit,
   input wire logic userBit,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   output logic rxStatusBlockFlag,
   output logic rxUserBufferFullFlag,
   output logic qSubcodeCrcError
);
   function automatic logic [7:0] csByte(input logic [191:0] v, input logic [4:0] k);
      return v[{k, 3'b000} +: 8];
   endfunction : csByte
   function automatic logic [95:0] qGather(input logic [767:0] u);
      logic [95:0] q;
      q = '0;
      for (int n = 0; n < 96; n++)
         q[95 - n] = u[n * 8 + 6];
      return q;
   endfunction : qGather
   function automatic logic qCrcOk(input logic [95:0] q);
      logic [15:0] crc;
      logic fb;
      crc = Q_INIT;
      for (int i = 0; i < Q_DATA_BITS; i++)
      begin
         fb = crc[15] ^ q[95 - i];
         crc = {crc[14:0], 1'b0} ^ (fb ? Q_POLY : 16'h0000);
      end
      return (Q_INVERT ? ~crc : crc) == q[15:0];
   endfunction : qCrcOk
   // link domain state
   logic [7:0] frameIdx_r;
   logic [7:0] curIdx;
   logic csArmed_r;
   logic [191:0] csFillA_r;
   logic [191:0] csFillB_r;
   logic [191:0] csHoldA_r;
   logic [191:0] csHoldB_r;
   logic csTog_r;
   logic [2:0] cfgS1_r;
   logic [2:0] cfgS2_r;
   logic [2:0] cfgS3_r;
   logic [2:0] cfgLink_r;
   logic [767:0] ubFill_r;
   logic [767:0] ubHold_r;
   logic [6:0] ubHoldIu_r;
   logic [9:0] ubCnt_r;
   logic ubArmed_r;
   logic ubTog_r;
   spdr_msg_e msgState_r;
   logic [2:0] bitCnt_r;
   logic [7:0] iuByte_r;
   logic [3:0] zeroRun_r;
   logic [6:0] iuCnt_r;
   logic isZ;
   logic isLeft;
   logic csDone;
   logic [9:0] ubLast;
   // system domain state
   logic [3:0] cfg_r;
   logic csSel_r;
   logic intMask_r;
   logic [6:0] ubAddr_r;
   logic [191:0] csA_r;
   logic [191:0] csB_r;
   logic [767:0] ub2_r;
   logic [6:0] iuCnt2_r;
   logic [79:0] qBuf_r;
   logic csFlag_r;
   logic ubFlag_r;
   logic qErr_r;
   spdr_ubm_e effMode;
   logic effSize;
   logic [2:0] cfgToLink;
   logic csPulse;
   logic ubPulse;
   logic csChanged;
   logic [95:0] qVec;
   logic rdStat;
   logic rdQ;
   logic rdUb;
   logic [6:0] ubWrap;
   spdr_evt_if csEvt ();
   spdr_evt_if ubEvt ();
   assign isZ = (subPreamble == PRE_Z_A) || (subPreamble == PRE_Z_B);
   assign isLeft = isZ || (subPreamble == PRE_X_A) || (subPreamble == PRE_X_B);
   always_comb
   begin
      if (isZ)
         curIdx = 8'h00;
      else if (isLeft)
         curIdx = frameIdx_r + 8'h01;
      else
         curIdx = frameIdx_r;
   end
   assign csDone = subValid && !isLeft && csArmed_r && (frameIdx_r == CS_LAST_IDX);
   always_ff @(posedge linkClk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         frameIdx_r <= 8'h00;
         csArmed_r <= 1'b0;
      end
      else if (subValid && isLeft)
      begin
         frameIdx_r <= curIdx;
         if (isZ)
            csArmed_r <= 1'b1;
      end
   end
   always_ff @(posedge linkClk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         csFillA_r <= '0;
         csFillB_r <= '0;
      end
      else if (subValid && isLeft)
         csFillA_r[curIdx] <= csBit;
      else if (subValid)
         csFillB_r[curIdx] <= csBit;
   end
   always_ff @(posedge linkClk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         csHoldA_r <= '0;
         csHoldB_r <= '0;
         csTog_r <= 1'b0;
      end
      else if (csDone)
      begin
         csHoldA_r <= csFillA_r;
         csHoldB_r <= {csBit, csFillB_r[190:0]};
         csTog_r <= !csTog_r;
      end
   end
   always_ff @(posedge linkClk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfgS1_r <= 3'h0;
         cfgS2_r <= 3'h0;
         cfgS3_r <= 3'h0;
         cfgLink_r <= 3'h0;
      end
      else
      begin
         cfgS1_r <= cfgToLink;
         cfgS2_r <= cfgS1_r;
         cfgS3_r <= cfgS2_r;
         if (cfgS2_r == cfgS3_r)
            cfgLink_r <= cfgS3_r;
      end
   end
   assign ubLast = cfgLink_r[0] ? UB_LAST_LARGE : UB_LAST_SMALL;
   // user capture: block mode fills from Z, message mode parses units
   always_ff @(posedge linkClk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ubFill_r <= '0;
         ubHold_r <= '0;
         ubHoldIu_r <= 7'h00;
         ubCnt_r <= 10'h000;
         ubArmed_r <= 1'b0;
         ubTog_r <= 1'b0;
         msgState_r <= MS_IDLE;
         bitCnt_r <= 3'h0;
         iuByte_r <= 8'h00;
         zeroRun_r <= 4'h0;
         iuCnt_r <= 7'h00;
      end
      else if (subValid && cfgLink_r[2:1] == 2'(UBM_BLOCK))
      begin
         if (isZ && !(cfgLink_r[0] && ubArmed_r && ubCnt_r == UB_LAST_SMALL + 10'h001))
         begin
            ubFill_r[0] <= userBit;
            ubCnt_r <= 10'h001;
            ubArmed_r <= 1'b1;
         end
         else if (ubArmed_r)
         begin
            ubFill_r[ubCnt_r] <= userBit;
            if (ubCnt_r == ubLast)
            begin
               ubHold_r <= ubFill_r;
               ubHold_r[ubCnt_r] <= userBit;
               ubHoldIu_r <= cfgLink_r[0] ? UB_BYTES_LARGE : UB_BYTES_SMALL;
               ubTog_r <= !ubTog_r;
               ubArmed_r <= 1'b0;
               ubCnt_r <= 10'h000;
            end
            else
               ubCnt_r <= ubCnt_r + 10'h001;
         end
      end
      else if (subValid && cfgLink_r[2:1] == 2'(UBM_MSG))
      begin
         case (msgState_r)
            MS_IDLE:
            begin
               if (userBit)
               begin
                  msgState_r <= MS_IU;
                  iuByte_r <= IU_LEAD;
                  bitCnt_r <= 3'h0;
               end
            end
            MS_IU:
            begin
               iuByte_r[3'(IU_LAST_BIT - bitCnt_r)] <= userBit;
               bitCnt_r <= bitCnt_r + 3'h1;
               if (bitCnt_r == IU_LAST_BIT)
               begin
                  if (iuCnt_r < IU_MAX)
                  begin
                     ubFill_r[{iuCnt_r, 3'b000} +: 8] <= {iuByte_r[7:1], userBit};
                     iuCnt_r <= iuCnt_r + 7'h01;
                  end
                  msgState_r <= MS_GAP;
                  zeroRun_r <= 4'h0;
               end
            end
            MS_GAP:
            begin
               if (userBit)
               begin
                  msgState_r <= MS_IU;
                  iuByte_r <= IU_LEAD;
                  bitCnt_r <= 3'h0;
               end
               else if (zeroRun_r == ZERO_END)
               begin
                  ubHold_r <= ubFill_r;
                  ubHoldIu_r <= iuCnt_r;
                  ubTog_r <= !ubTog_r;
                  iuCnt_r <= 7'h00;
                  msgState_r <= MS_IDLE;
               end
               else
                  zeroRun_r <= zeroRun_r + 4'h1;
            end
            default:
               msgState_r <= MS_IDLE;
         endcase
      end
   end
   assign csEvt.srcTog = csTog_r;
   assign ubEvt.srcTog = ubTog_r;
   spdr_evt_sync uCsSync (.clk(sys_clk), .arst_n(arst_n), .evt(csEvt));
   spdr_evt_sync uUbSync (.clk(sys_clk), .arst_n(arst_n), .evt(ubEvt));
   assign csPulse = csEvt.dstPulse;
   assign ubPulse = ubEvt.dstPulse;
   // effective user-bit handling
   always_comb
   begin
      effSize = cfg_r[CFG_SIZE_BIT];
      case (cfg_r[CFG_MODE_LSB +: 2])
         UBM_CFG_BLOCK: effMode = UBM_BLOCK;
         UBM_CFG_AUTO:
         begin
            if (!csA_r[PRO_BIT])
               effMode = UBM_MSG;
            else
            begin
               case (csA_r[CAT_LSB +: 4])
                  CAT_AES18: effMode = UBM_BLOCK;
                  CAT_USER: effMode = UBM_BLOCK;
                  CAT_SMALL:
                  begin
                     effMode = UBM_BLOCK;
                     effSize = 1'b0;
                  end
                  default: effMode = UBM_OFF;
               endcase
            end
         end
         default: effMode = UBM_OFF;
      endcase
   end
   assign cfgToLink = {2'(effMode), effSize};
   assign rdStat = regRdEn && (regAddr == REG_INTSTAT);
   assign rdQ = regRdEn && (regAddr == REG_QSTAT);
   assign rdUb = regRdEn && (regAddr == REG_UBDATA);
   assign ubWrap = (effMode == UBM_BLOCK && !effSize) ? UB_BYTES_SMALL : UB_BYTES_LARGE;
   assign csChanged = (csHoldA_r[CMP_BITS-1:0] != csA_r[CMP_BITS-1:0])
      || (csHoldB_r[CMP_BITS-1:0] != csB_r[CMP_BITS-1:0]);
   assign qVec = qGather(ubHold_r);
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_r <= CFG_RST;
         csSel_r <= CSSEL_RST;
         intMask_r <= MASK_RST;
      end
      else if (regWrEn)
      begin
         if (regAddr == REG_CFG)
            cfg_r <= regWrData[3:0];
         if (regAddr == REG_CSSEL)
            csSel_r <= regWrData[0];
         if (regAddr == REG_INTMASK)
            intMask_r <= regWrData[INT_UB_BIT];
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         ubAddr_r <= 7'h00;
      else if (regWrEn && regAddr == REG_UBADDR)
         ubAddr_r <= regWrData[6:0];
      else if (rdUb)
         ubAddr_r <= (ubAddr_r + 7'h01 >= ubWrap) ? 7'h00 : ubAddr_r + 7'h01;
   end
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         csA_r <= '0;
         csB_r <= '0;
         csFlag_r <= 1'b0;
      end
      else
      begin
         if (csPulse)
         begin
            csA_r <= csHoldA_r;
            csB_r <= csHoldB_r;
         end
         if (csPulse && (!cfg_r[CFG_FLAGMODE_BIT] || csChanged))
            csFlag_r <= 1'b1;
         else if (rdStat)
            csFlag_r <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ub2_r <= '0;
         iuCnt2_r <= 7'h00;
         ubFlag_r <= 1'b0;
      end
      else
      begin
         if (ubPulse)
         begin
            ub2_r <= ubHold_r;
            iuCnt2_r <= ubHoldIu_r;
         end
         if (ubPulse && intMask_r)
            ubFlag_r <= 1'b1;
         else if (rdStat)
            ubFlag_r <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         qBuf_r <= '0;
         qErr_r <= 1'b0;
      end
      else
      begin
         if (ubPulse && effMode == UBM_MSG && ubHoldIu_r >= IU_MAX)
            qBuf_r <= qVec[95:16];
         if (ubPulse && effMode == UBM_MSG && ubHoldIu_r >= IU_MAX && !qCrcOk(qVec))
            qErr_r <= 1'b1;
         else if (rdQ)
            qErr_r <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         regRdData <= 8'h00;
      else if (regRdEn)
      begin
         if (regAddr >= CS_BASE && regAddr <= CS_LAST)
            regRdData <= csByte(csSel_r ? csB_r : csA_r, 5'(regAddr - CS_BASE));
         else if (regAddr >= Q_BASE && regAddr <= Q_LAST)
            regRdData <= qBuf_r[7'(79 - 8 * (regAddr - Q_BASE)) -: 8];
         else
         begin
            case (regAddr)
               REG_CFG: regRdData <= {4'h0, cfg_r};
               REG_CSSEL: regRdData <= {7'h00, csSel_r};
               REG_INTSTAT: regRdData <= {6'h00, ubFlag_r, csFlag_r};
               REG_INTMASK: regRdData <= {6'h00, intMask_r, 1'b0};
               REG_UBADDR: regRdData <= {1'b0, ubAddr_r};
               REG_UBDATA: regRdData <= ub2_r[{ubAddr_r, 3'b000} +: 8];
               REG_QSTAT: regRdData <= {7'h00, qErr_r};
               REG_IUCNT: regRdData <= {1'b0, iuCnt2_r};
               default: regRdData <= 8'h00;
            endcase
         end
      end
   end
   assign rxStatusBlockFlag = csFlag_r;
   assign rxUserBufferFullFlag = ubFlag_r;
   assign qSubcodeCrcError = qErr_r;
   property p_cs_read;
      @(posedge sys_clk) disable iff (!arst_n)
      regRdEn && regAddr == CS_BASE |=> regRdData == ($past(csSel_r) ? $past(csB_r[7:0]) : $past(csA_r[7:0]));
   endproperty
   a_cs_read: assert property (p_cs_read) else $error("status byte 0 read wrong");
   property p_ub_data;
      @(posedge sys_clk) disable iff (!arst_n)
      rdUb |=> regRdData == $past(ub2_r[{ubAddr_r, 3'b000} +: 8]);
   endproperty
   a_ub_data: assert property (p_ub_data) else $error("user data read wrong");
   property p_ub_adv;
      @(posedge sys_clk) disable iff (!arst_n)
      rdUb && !regWrEn && ubAddr_r == 7'h00 |=> ubAddr_r == 7'h01;
   endproperty
   a_ub_adv: assert property (p_ub_adv) else $error("user address did not advance");
   property p_cs_flag;
      @(posedge sys_clk) disable iff (!arst_n)
      csPulse && !cfg_r[CFG_FLAGMODE_BIT] |=> csFlag_r && csA_r == $past(csHoldA_r);
   endproperty
   a_cs_flag: assert property (p_cs_flag) else $error("block flag not set");
   property p_stat_clear;
      @(posedge sys_clk) disable iff (!arst_n)
      rdStat && !csPulse && !ubPulse |=> !csFlag_r && !ubFlag_r;
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status read did not clear");
   property p_ub_mask;
      @(posedge sys_clk) disable iff (!arst_n)
      !intMask_r && !ubFlag_r |=> !ubFlag_r;
   endproperty
   a_ub_mask: assert property (p_ub_mask) else $error("masked user flag set");
   property p_qerr_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      qErr_r && !rdQ |=> qErr_r;
   endproperty
   a_qerr_hold: assert property (p_qerr_hold) else $error("crc error dropped early");
   property p_cs_done;
      @(posedge linkClk) disable iff (!arst_n)
      $changed(csTog_r) |-> $past(subValid && !isLeft && frameIdx_r == CS_LAST_IDX);
   endproperty
   a_cs_done: assert property (p_cs_done) else $error("block handed over early");
   property p_msg_end;
      @(posedge linkClk) disable iff (!arst_n)
      subValid && msgState_r == MS_GAP && zeroRun_r == ZERO_END && !userBit
         && cfgLink_r[2:1] == 2'(UBM_MSG) |=> $changed(ubTog_r) && msgState_r == MS_IDLE;
   endproperty
   a_msg_end: assert property (p_msg_end) else $error("message end missed");
endmodule : spdr_rx_buffers

// file: verification/spdr_src_model.sv
// source model sending decoded subframes on the link clock
`timescale 1ns/1ps
module spdr_src_model
   import spdr_pkg::*;
(
   input wire logic linkClk,
   output logic subValid,
   output logic [7:0] subPreamble,
   output logic csBit,
   output logic userBit
);
   logic [191:0] csA;
   logic [191:0] csB;
   int sub = 0;
   int gap = 0;
   initial
   begin
      subValid = 1'b0;
      subPreamble = 8'h00;
      csBit = 1'b0;
      userBit = 1'b0;
      csA = '0;
      csB = '0;
   end
   // left then right; z opens each 192-frame block; released lines show the inverse
   task automatic send(input logic u);
      @(posedge linkClk);
      subValid <= 1'b1;
      subPreamble <= (sub == 0) ? PRE_Z_A : ((sub % 2 == 1) ? 8'he4 : PRE_X_A);
      csBit <= (sub % 2 == 1) ? csB[sub / 2] : csA[sub / 2];
      userBit <= u;
      @(posedge linkClk);
      subValid <= 1'b0;
      subPreamble <= ~subPreamble;
      csBit <= ~csBit;
      userBit <= ~userBit;
      repeat (gap) @(posedge linkClk);
      sub = (sub + 1) % 384;
   endtask : send
endmodule : spdr_src_model

// file: verification/tb_top.sv
// testbench for the receive status and user buffers
`timescale 1ns/1ps
module tb_top
   import spdr_pkg::*;
;
   logic sys_clk = 1'b0;
   logic linkClk = 1'b0;
   logic arst_n = 1'b0;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData;
   logic [7:0] subPreamble;
   logic subValid, csBit, userBit, csFlag, ubFlag, qErr;
   int errorCnt = 0;
   int cmpCount = 0;
   spdr_rx_buffers spdr_rx_buffers_inst (.sys_clk(sys_clk), .arst_n(arst_n), .linkClk(linkClk),
      .subValid(subValid), .subPreamble(subPreamble), .csBit(csBit), .userBit(userBit),
      .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(regRdData), .rxStatusBlockFlag(csFlag), .rxUserBufferFullFlag(ubFlag),
      .qSubcodeCrcError(qErr));
   spdr_src_model spdr_src_model_inst (.linkClk(linkClk), .subValid(subValid),
      .subPreamble(subPreamble), .csBit(csBit), .userBit(userBit));
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end
   initial
   begin
      #37;
      forever #80 linkClk = ~linkClk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmpCount++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= v;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      #1;
      chk(regRdData, exp);
   endtask : rc
   function automatic logic [7:0] csb(int k, bit chB, bit alt);
      return 8'(k * 29 + 64) ^ (chB ? 8'h5a : 8'h00) ^ ((alt && k == 4) ? 8'h10 : 8'h00);
   endfunction : csb
   function automatic logic [7:0] ub(int j);
      return 8'(j * 3 + 17);
   endfunction : ub
   // q bit of unit n: data bits then the inverted crc, spoiled when good is clear
   function automatic logic qb(int n, bit good);
      logic [15:0] c;
      c = Q_INIT;
      for (int i = 0; i < Q_DATA_BITS; i++)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ (i % 8 == 0)) ? Q_POLY : 16'h0000);
      return (n < Q_DATA_BITS) ? (n % 8 == 0) : (c[95 - n] ^ Q_INVERT ^ !good);
   endfunction : qb
   task automatic blk(input bit alt, input int stopAt, input logic [7:0] adr,
      input logic [7:0] exp);
      logic [7:0] b;
      for (int k = 0; k < 192; k++)
      begin
         b = csb(k / 8, 1'b0, alt);
         spdr_src_model_inst.csA[k] = b[k % 8];
         b = csb(k / 8, 1'b1, alt);
         spdr_src_model_inst.csB[k] = b[k % 8];
      end
      for (int i = 0; i < 384; i++)
      begin
         if (i == stopAt)
            rc(adr, exp);
         b = ub(i / 8);
         spdr_src_model_inst.send(b[i % 8]);
      end
      repeat (30) @(posedge sys_clk);
   endtask : blk
   task automatic msg(input bit tail);
      logic [7:0] u;
      repeat (4) spdr_src_model_inst.send(1'b0);
      for (int n = 0; n < 96; n++)
      begin
         u = {1'b1, qb(n, tail), 6'h19};
         for (int i = 7; i >= 0; i--)
            spdr_src_model_inst.send(u[i]);
         repeat (2) spdr_src_model_inst.send(1'b0);
      end
      repeat (10) spdr_src_model_inst.send(1'b0);
      repeat (30) @(posedge sys_clk);
   endtask : msg
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
      if (errorCnt == 0 && cmpCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   task automatic t_reset;
      chk({5'h0, csFlag, ubFlag, qErr}, 8'h00);
      rc(REG_CFG, {4'h0, CFG_RST});
      rc(REG_CSSEL, 8'h00);
      rc(REG_INTMASK, 8'h00);
      wr(8'h40, 8'hff);
      rc(8'h40, 8'h00);
      rc(CS_BASE, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_cs;
      wr(REG_CFG, 8'h02);
      repeat (20) @(posedge sys_clk);
      blk(1'b0, 200, CS_BASE, 8'h00);
      chk({6'h0, ubFlag, csFlag}, 8'h01);
      for (int k = 0; k < 24; k++) rc(CS_BASE + 8'(k), csb(k, 1'b0, 1'b0));
      wr(REG_CSSEL, 8'h01);
      rc(REG_CSSEL, 8'h01);
      for (int k = 0; k < 24; k++) rc(CS_BASE + 8'(k), csb(k, 1'b1, 1'b0));
      wr(REG_CSSEL, 8'h00);
      rc(REG_INTSTAT, 8'h01);
      chk({7'h0, csFlag}, 8'h00);
      $display("test status block done");
   endtask : t_cs
   task automatic t_user;
      wr(REG_INTMASK, 8'h02);
      wr(REG_CFG, 8'h0a);
      repeat (20) @(posedge sys_clk);
      blk(1'b0, -1, CS_BASE, 8'h00);
      chk({6'h0, ubFlag, csFlag}, 8'h02);
      rc(REG_IUCNT, 8'h30);
      wr(REG_UBADDR, 8'h05);
      rc(REG_UBDATA, ub(5));
      rc(REG_UBADDR, 8'h06);
      wr(REG_UBADDR, 8'h00);
      for (int j = 0; j < 49; j++) rc(REG_UBDATA, ub(j % 48));
      rc(REG_INTSTAT, 8'h02);
      wr(REG_CFG, 8'h0b);
      repeat (20) @(posedge sys_clk);
      blk(1'b0, -1, CS_BASE, 8'h00);
      chk({7'h0, ubFlag}, 8'h00);
      blk(1'b0, -1, CS_BASE, 8'h00);
      chk({6'h0, ubFlag, csFlag}, 8'h02);
      rc(REG_IUCNT, 8'h60);
      wr(REG_UBADDR, 8'h5f);
      rc(REG_UBDATA, ub(47));
      rc(REG_UBADDR, 8'h00);
      rc(REG_INTSTAT, 8'h02);
      wr(REG_CFG, 8'h0a);
      repeat (20) @(posedge sys_clk);
      $display("test user block done");
   endtask : t_user
   task automatic t_change;
      blk(1'b1, 200, CS_BASE + 8'h04, csb(4, 1'b0, 1'b0));
      chk({7'h0, csFlag}, 8'h01);
      rc(CS_BASE + 8'h04, csb(4, 1'b0, 1'b1));
      rc(REG_INTSTAT, 8'h03);
      $display("test status change done");
   endtask : t_change
   task automatic t_msg;
      wr(REG_CFG, 8'h04);
      repeat (20) @(posedge sys_clk);
      spdr_src_model_inst.gap = 2;
      msg(1'b1);
      chk({6'h0, ubFlag, qErr}, 8'h02);
      rc(REG_IUCNT, 8'h60);
      wr(REG_UBADDR, 8'h00);
      rc(REG_UBDATA, 8'hd9);
      rc(Q_BASE, 8'h80);
      rc(Q_LAST, 8'h80);
      msg(1'b0);
      chk({7'h0, qErr}, 8'h01);
      rc(REG_QSTAT, 8'h01);
      chk({7'h0, qErr}, 8'h00);
      $display("test message done");
   endtask : t_msg
   initial
   begin
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_reset();
      t_cs();
      t_user();
      t_change();
      t_msg();
      tally_and_finish();
   end
   initial
   begin
      repeat (40000) @(posedge sys_clk);
      errorCnt++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule : tb_top
